//--- rtl/config_crc_and_retention_regs.v
// Configuration checksum engine, covered settings registers and retention word behind an APB slave.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "cfg_crc_consts.vh"

module config_crc_and_retention_regs (
	// Clock and reset.
	input  wire        pclk,
	input  wire        presetn,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [15:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Power mode pin, high while the device is in Active mode.
	input  wire        active_mode,
	// Checksum engine state.
	output reg         crc_busy
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN  = 2'b10;

	// Covered settings words, slot 0 is the general alarm settings.
	reg  [15:0] cfg_mem [0:`CFG_COUNT-1];

	// Retention word and checksum state.
	reg  [15:0] deep_sleep_retention_word_1;
	reg  [15:0] configuration_checksum;
	reg  [15:0] crc_acc;
	reg  [3:0]  crc_slot;
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg         crc_done;

	// Active mode pin synchroniser and edge history.
	reg         act_meta;
	reg         act_sync;
	reg         act_prev;

	// Bus decode.
	wire [13:0] idx;
	wire        aligned;
	wire        setup_phase;
	wire        access_phase;
	wire        wr_access;
	wire        rd_access;
	wire        mapped;
	wire        cfg_hit;
	wire [3:0]  cfg_idx;

	// Engine control.
	wire        active_entry;
	wire        cfg_write;
	wire        checksum_read;
	wire        crc_start;
	wire [15:0] crc_next;
	reg  [31:0] next_rdata;

	integer k;

	// True when an index falls inside the covered set.
	function is_cfg;
		input [13:0] i;
		begin
			is_cfg = (i >= `CFG_FIRST) && (i < (`CFG_FIRST + `CFG_COUNT));
		end
	endfunction

	// Slot of a covered index inside the settings array.
	function [3:0] cfg_slot;
		input [13:0] i;
		reg   [13:0] d;
		begin
			d = i - `CFG_FIRST;
			cfg_slot = d[3:0];
		end
	endfunction

	// Write mask of a covered slot; reserved alarm bits stay zero.
	function [15:0] cfg_mask;
		input [3:0] s;
		begin
			cfg_mask = (s == 4'h0) ? `ALARM_WMASK : 16'hFFFF;
		end
	endfunction

	assign idx          = paddr[15:2];
	assign aligned      = (paddr[1:0] == 2'b00);
	assign setup_phase  = psel & ~penable;
	assign access_phase = psel & penable;
	assign cfg_hit      = aligned & is_cfg(idx);
	assign cfg_idx      = cfg_slot(idx);

	assign mapped = aligned & ((idx == `IDX_RETENTION) | (idx == `IDX_CHECKSUM) |
	                           (idx == `IDX_STATUS) | is_cfg(idx));

	// Every access completes without wait states; prdata was captured in the setup cycle.
	assign pready  = 1'b1;
	assign pslverr = access_phase & ~mapped;

	assign wr_access = access_phase & pwrite & mapped;
	assign rd_access = access_phase & ~pwrite & mapped;

	// Read mux, sampled in the setup cycle so that prdata comes straight from a flip-flop.
	always @* begin
		next_rdata = 32'h0000_0000;
		if (aligned) begin
			if (idx == `IDX_RETENTION) begin
				next_rdata[15:0] = deep_sleep_retention_word_1;
			end else if (idx == `IDX_CHECKSUM) begin
				next_rdata[15:0] = configuration_checksum;
			end else if (idx == `IDX_STATUS) begin
				next_rdata[`STATUS_BUSY_BIT] = crc_busy;
				next_rdata[`STATUS_DONE_BIT] = crc_done;
			end else if (is_cfg(idx)) begin
				next_rdata[15:0] = cfg_mem[cfg_idx] & cfg_mask(cfg_idx);
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata <= next_rdata;
		end
	end

	// The retention word sits in the always-on supply and has no reset at all.
	// It feeds only the read mux, so no stored value can alter device behaviour.
	always @(posedge pclk) begin
		if (wr_access && idx == `IDX_RETENTION) begin
			deep_sleep_retention_word_1 <= pwdata[15:0];
		end
	end

	// Covered settings registers.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (k = 0; k < `CFG_COUNT; k = k + 1) begin
				cfg_mem[k] <= `CFG_RESET;
			end
		end else if (wr_access && cfg_hit) begin
			cfg_mem[cfg_idx] <= pwdata[15:0] & cfg_mask(cfg_idx);
		end
	end

	// The mode pin comes from another supply domain and is synchronised before use.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_meta <= 1'b0;
			act_sync <= 1'b0;
			act_prev <= 1'b0;
		end else begin
			act_meta <= active_mode;
			act_sync <= act_meta;
			act_prev <= act_sync;
		end
	end

	assign active_entry  = act_sync & ~act_prev;
	assign cfg_write     = wr_access & cfg_hit;
	assign checksum_read = rd_access & (idx == `IDX_CHECKSUM);

	// A new trigger during a run restarts from the first slot, so the value that
	// finally lands always reflects every write made before the last trigger.
	assign crc_start = active_entry | cfg_write | checksum_read;

	crc16_word_step u_step (
		.crc_in  (crc_acc),
		.data_in (cfg_mem[crc_slot]),
		.crc_out (crc_next)
	);

	always @* begin
		case (state)
			ST_IDLE: begin
				next_state = crc_start ? ST_RUN : ST_IDLE;
			end
			ST_RUN: begin
				if (crc_start) begin
					next_state = ST_RUN;
				end else if (crc_slot == `CFG_LAST_SLOT) begin
					next_state = ST_IDLE;
				end else begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// One covered word per clock: twelve cycles per run, far inside the
	// CRC_LIMIT_CYCLES budget, which is why no faster parallel engine is used.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state                  <= ST_IDLE;
			crc_acc                <= `CRC_INIT;
			crc_slot               <= 4'h0;
			crc_busy               <= 1'b0;
			crc_done               <= 1'b0;
			configuration_checksum <= `CHECKSUM_RESET;
		end else begin
			state <= next_state;
			if (crc_start) begin
				crc_acc  <= `CRC_INIT;
				crc_slot <= 4'h0;
				crc_busy <= 1'b1;
			end else if (state == ST_RUN) begin
				crc_acc  <= crc_next;
				crc_slot <= crc_slot + 4'h1;
				if (crc_slot == `CFG_LAST_SLOT) begin
					crc_busy <= 1'b0;
				end
			end
			// The visible value changes only when a full pass over the set ends.
			if (state == ST_RUN && !crc_start && crc_slot == `CFG_LAST_SLOT) begin
				configuration_checksum <= crc_next;
				crc_done               <= 1'b1;
			end
		end
	end

endmodule // config_crc_and_retention_regs

//--- rtl/cfg_crc_consts.vh
// Register indices, field layouts, reset values and timing counts of the configuration checksum block.
`ifndef CFG_CRC_CONSTS_VH
`define CFG_CRC_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_RETENTION      14'h0081
`define IDX_CHECKSUM       14'h0400
`define IDX_ALARM_GENERAL  14'h0401
`define IDX_ALARM_OUT_A    14'h0402
`define IDX_ALARM_OUT_B    14'h0403
`define IDX_WAKEUP_A       14'h0404
`define IDX_SUPPLY_RST     14'h0405
`define IDX_COMM_RST       14'h0406
`define IDX_SUPPLY_EVT     14'h0407
`define IDX_ANALOG_EVT_A   14'h0408
`define IDX_COMM_EVT_B     14'h0409
`define IDX_ANALOG_EVT     14'h040A
`define IDX_COMM_EVT       14'h040B
`define IDX_MEAS_EVT       14'h040C
`define IDX_STATUS         14'h040F

// Covered set: first index, number of words and last slot.
`define CFG_FIRST          14'h0401
`define CFG_COUNT          12
`define CFG_LAST_SLOT      4'hB

// General alarm settings: bits 15:9 are reserved and read as zero.
`define ALARM_WMASK        16'h01FF
`define ALARM_IN_SEL_LSB   0
`define ALARM_IN_HB_LSB    2
`define ALARM_OUT_SEL_LSB  4
`define ALARM_OUT_HB_LSB   6
`define HB_IN_INVERT_BIT   8

// Reset values.
`define CFG_RESET          16'h0000
`define CHECKSUM_RESET     16'h0000

// Polynomial in normal form, leading term dropped, and start value.
`define CRC_POLY           16'hA2EB
`define CRC_INIT           16'hFFFF

// Status register fields.
`define STATUS_BUSY_BIT    0
`define STATUS_DONE_BIT    1

// Latest time from a covered write to a readable checksum.
`define CRC_LIMIT_NS       100000
`define CLK_PERIOD_PS      25000
`define CRC_LIMIT_CYCLES   ((`CRC_LIMIT_NS * 1000) / `CLK_PERIOD_PS)

`endif

//--- rtl/crc16_word_step.v
// One sixteen-bit word folded into the configuration checksum, most significant bit first.
`timescale 1ns/1ps
`include "cfg_crc_consts.vh"

module crc16_word_step (
	// Running checksum and next word.
	input  wire [15:0] crc_in,
	input  wire [15:0] data_in,
	// Updated checksum.
	output reg  [15:0] crc_out
);

	integer i;
	reg     fb;

	always @* begin
		crc_out = crc_in;
		fb = 1'b0;
		for (i = 15; i >= 0; i = i - 1) begin
			fb = crc_out[15] ^ data_in[i];
			crc_out = {crc_out[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
		end
	end

endmodule // crc16_word_step

//--- dv/cfg_crc_checker.sv
// Port-level assertions for the configuration checksum block.
`timescale 1ns/1ps
module cfg_crc_checker (
	// Clock, reset and bus.
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Power mode and engine state.
	input wire        active_mode,
	input wire        crc_busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	a_write_starts_run: assert property (acc && pwrite && paddr == 16'h1004 |=> crc_busy)
		else $error("covered write did not start a run");
	a_read_starts_run: assert property (acc && !pwrite && paddr == 16'h1000 |=> crc_busy)
		else $error("checksum read did not start a run");
	a_active_starts_run: assert property ($rose(active_mode) |-> ##[1:5] crc_busy)
		else $error("active entry did not start a run");
	// A run takes twelve cycles; retriggers may stretch it, far below the 100 us limit.
	a_run_length: assert property ($rose(crc_busy) |-> ##[12:200] !crc_busy)
		else $error("run length out of range");
	a_read_width: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_retention_inert: assert property (acc && pwrite && paddr == 16'h0204 && !crc_busy |=> !crc_busy)
		else $error("retention write started a run");
	a_unaligned_error: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("unaligned access not refused");
	a_reset_clears: assert property (disable iff (1'b0) !presetn |-> !crc_busy && prdata == 32'h0)
		else $error("outputs not cleared in reset");
	cover property (acc && pwrite && paddr == 16'h1004);
	cover property ($rose(crc_busy));
	cover property ($rose(active_mode));
endmodule // cfg_crc_checker
bind config_crc_and_retention_regs cfg_crc_checker i_cfg_crc_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .active_mode(active_mode), .crc_busy(crc_busy));

//--- dv/tb.sv
// Self-checking bench for the configuration checksum block.
`timescale 1ns/1ps
module tb;
	reg         pclk = 1'b0;
	reg         presetn = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [15:0] paddr = 16'h0000;
	reg  [31:0] pwdata = 32'h0;
	reg         active_mode = 1'b0;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        crc_busy;
	integer     errors = 0;
	integer     tests_run = 0;
	integer     i;
	reg  [15:0] cfg [0:11];
	reg  [51:0] rows [0:6];
	reg  [31:0] rd;
	reg         er;
	reg  [15:0] old;
	always #12.5 pclk = ~pclk;
	config_crc_and_retention_regs i_config_crc_and_retention_regs (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .active_mode(active_mode), .crc_busy(crc_busy));
	// Reference checksum: slots in index order, each word most significant bit first.
	function [15:0] crc_of();
		integer w, b;
		reg [15:0] c;
		c = 16'hFFFF;
		for (w = 0; w < 12; w++)
			for (b = 15; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ cfg[w][b]) ? 16'hA2EB : 16'h0000);
		return c;
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input w, input [15:0] a, input [15:0] d, output [31:0] r, output e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// The first edge lets a just-launched run show busy before the wait starts.
	task wait_idle;
		integer n;
		n = 0;
		@(posedge pclk);
		while (crc_busy !== 1'b0 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(crc_busy), 32'h0);
	endtask
	task read_crc(input [15:0] exp);
		apb(1'b0, 16'h1000, 16'h0000, rd, er);
		chk(rd, {16'h0000, exp});
	endtask
	task conclude;
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		conclude;
	end
	initial begin
		// A real falling edge at time zero lets the asynchronous reset act before the first clock.
		presetn <= 1'b0;
		for (i = 0; i < 12; i++) cfg[i] = 16'h0000;
		rows[0] = 52'h0_1000_5555_0000;
		rows[1] = 52'h0_1004_FFFF_01FF;
		rows[2] = 52'h0_1008_1234_1234;
		rows[3] = 52'h0_1030_8001_8001;
		rows[4] = 52'h0_0204_A5C3_A5C3;
		rows[5] = 52'h1_0008_1111_0000;
		rows[6] = 52'h1_1006_2222_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 7; i++) begin
			apb(1'b1, rows[i][47:32], rows[i][31:16], rd, er);
			chk(32'(er), 32'(rows[i][48]));
			apb(1'b0, rows[i][47:32], 16'h0000, rd, er);
			chk(rd, {16'h0000, rows[i][15:0]});
			if (rows[i][47:32] >= 16'h1004 && rows[i][47:32] <= 16'h1030 && rows[i][33:32] == 2'b00)
				cfg[(rows[i][47:32] - 16'h1004) >> 2] = rows[i][15:0];
		end
		wait_idle;
		apb(1'b0, 16'h103C, 16'h0000, rd, er);
		chk(rd, 32'h0000_0002);
		read_crc(crc_of());
		@(posedge pclk);
		chk(32'(crc_busy), 32'h1);
		old = crc_of();
		wait_idle;
		apb(1'b1, 16'h102C, 16'hBEEF, rd, er);
		cfg[10] = 16'hBEEF;
		read_crc(old);
		wait_idle;
		read_crc(crc_of());
		// Reset lands while a run is in flight; only the retention word may keep its value.
		apb(1'b1, 16'h1004, 16'h0003, rd, er);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 12; i++) cfg[i] = 16'h0000;
		read_crc(16'h0000);
		wait_idle;
		apb(1'b0, 16'h0204, 16'h0000, rd, er);
		chk(rd, 32'h0000A5C3);
		apb(1'b1, 16'h0204, 16'h0F0F, rd, er);
		@(posedge pclk);
		chk(32'(crc_busy), 32'h0);
		active_mode <= 1'b1;
		repeat (6) @(posedge pclk);
		wait_idle;
		read_crc(crc_of());
		conclude;
	end
endmodule // tb
